//--- logic/rpp_regs.sv
/*
  Per-redistributor register slice: partition ids, pending-table base,
  Non-secure software-interrupt permission levels. Assumes a synchronous word port
  from the redistributor's decoder; read data one cycle after request.
*/
`timescale 1ns/1ps
`include "rpp_params.svh"

module rpp_regs #(
  parameter int unsigned PA_BITS = 52
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic        req_in,
  input  wire logic        write_in,
  input  wire logic        frame_in,
  input  wire logic [11:0] offset_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        secure_in,
  output logic             rvalid_out,
  output logic [31:0]      rdata_out,
  // Configuration
  input  wire logic        security_disable_in,
  input  wire logic        rev_supported_in,
  input  wire logic        mem_partition_support_in,
  input  wire logic        affinity_routing_in,
  input  wire logic        msg_intr_enable_in,
  // Memory access attributes
  output logic [15:0]      partition_id_out,
  output logic [7:0]       perf_monitor_group_out,
  output logic [35:0]      pend_addr_out,
  output logic [2:0]       outer_cacheability_out,
  output logic [2:0]       inner_cacheability_out,
  output logic [1:0]       shareability_out,
  output logic             pending_table_zero_out,
  // Software-interrupt permission levels, two bits each
  output logic [31:0]      nonsecure_sgi_level_out
);

  localparam logic [63:0] PA_MASK = (PA_BITS >= 52) ? 64'hffff_ffff_ffff_ffff :
                                    ((64'h1 << PA_BITS) - 64'h1);

  logic [31:0] part_q;
  logic [31:0] part_d;
  logic [63:0] pend_q;
  logic [63:0] pend_d;
  logic [31:0] perm_q;
  logic [31:0] perm_d;
  logic        hint_q;
  logic        hint_d;

  // Effective level: reserved code behaves as the top valid code
  function automatic logic [1:0] rpp_level(input logic [1:0] raw);
    rpp_level = (raw == `RPP_LEVEL_RSVD) ? `RPP_LEVEL_MAX : raw;
  endfunction : rpp_level

  wire is_ctrl = frame_in == rpp_pkg::RPP_FRAME_CTRL;
  wire is_swi  = frame_in == rpp_pkg::RPP_FRAME_SWI;
  wire hit_part = req_in && is_ctrl && offset_in == `RPP_OFS_PARTITION;
  wire hit_plo  = req_in && is_ctrl && offset_in == `RPP_OFS_PEND_LO;
  wire hit_phi  = req_in && is_ctrl && offset_in == `RPP_OFS_PEND_HI;
  wire hit_perm = req_in && is_swi && offset_in == `RPP_OFS_SWI_PERM;

  // partition register present only when supported
  wire part_live = rev_supported_in && mem_partition_support_in;
  // Secure-only when security enabled, absent otherwise
  wire perm_live = !security_disable_in && secure_in;

  wire wr_part = hit_part && write_in && part_live;
  wire wr_plo  = hit_plo && write_in;
  wire wr_phi  = hit_phi && write_in;
  wire wr_perm = hit_perm && write_in && perm_live;

  // both Security states reach partition and pending base
  assign part_d = wr_part ? (wdata_in & `RPP_PART_MASK) : part_q;

  // attribute and address fields programmable; upper PA bits masked
  wire [63:0] pend_wr = {wr_phi ? wdata_in : pend_q[63:32],
                         wr_plo ? wdata_in : pend_q[31:0]};
  assign pend_d = pend_wr & `RPP_PEND_MASK & PA_MASK | (pend_wr & `RPP_PEND_MASK & ~64'h000f_ffff_ffff_0000);

  // pending_table_zero captured, never stored in readable image
  assign hint_d = wr_phi ? wdata_in[`RPP_ZERO_HINT_BIT - 32] : hint_q;
  assign perm_d = wr_perm ? wdata_in : perm_q;

  // reserved bits read zero; bit 62 reads zero
  wire [31:0] rd_part = part_live ? part_q : `RPP_RESET_WORD;
  wire [31:0] rd_perm = perm_live ? perm_q : `RPP_RESET_WORD;
  wire [31:0] rd_mux  = hit_part ? rd_part :
                        hit_plo  ? pend_q[31:0] :
                        hit_phi  ? pend_q[63:32] :
                        hit_perm ? rd_perm : `RPP_RESET_WORD;
  wire [31:0] rdata_d = (req_in && !write_in) ? rd_mux : `RPP_RESET_WORD;

  wire [1:0] share_raw = pend_q[`RPP_SHARE_MSB:`RPP_SHARE_LSB];
  wire [1:0] share_eff = (share_raw == `RPP_SHARE_RSVD) ? `RPP_SHARE_NONE : share_raw;

  // per-interrupt levels, forced to none without affinity routing
  logic [31:0] level_d;
  genvar g;
  generate
    for (g = 0; g < `RPP_SWI_COUNT; g++) begin : g_lvl
      assign level_d[2*g+1:2*g] = (affinity_routing_in && !security_disable_in) ?
                                  rpp_level(perm_q[2*g+1:2*g]) : 2'h0;
    end
  endgenerate

  // storage reset to zero only so outputs are defined
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      part_q <= `RPP_RESET_WORD;
      pend_q <= `RPP_RESET_DWORD;
      perm_q <= `RPP_RESET_WORD;
      hint_q <= 1'b0;
    end else begin
      part_q <= part_d;
      pend_q <= pend_d;
      perm_q <= perm_d;
      hint_q <= hint_d;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_out              <= 1'b0;
      rdata_out               <= `RPP_RESET_WORD;
      partition_id_out        <= 16'h0000;
      perf_monitor_group_out  <= 8'h00;
      pend_addr_out           <= 36'h0_0000_0000;
      outer_cacheability_out  <= 3'h0;
      inner_cacheability_out  <= 3'h0;
      shareability_out        <= 2'h0;
      pending_table_zero_out  <= 1'b0;
      nonsecure_sgi_level_out <= `RPP_RESET_WORD;
    end else begin
      rvalid_out              <= req_in && !write_in;
      rdata_out               <= rdata_d;
      partition_id_out        <= part_live ? part_q[`RPP_PART_ID_MSB:0] : 16'h0000;
      perf_monitor_group_out  <= part_live ? part_q[`RPP_PERF_GRP_MSB:`RPP_PERF_GRP_LSB] : 8'h00;
      pend_addr_out           <= pend_q[`RPP_ADDR_MSB:`RPP_ADDR_LSB];
      outer_cacheability_out  <= pend_q[`RPP_OUTER_MSB:`RPP_OUTER_LSB];
      inner_cacheability_out  <= pend_q[`RPP_INNER_MSB:`RPP_INNER_LSB];
      shareability_out        <= share_eff;
      pending_table_zero_out  <= hint_q && !msg_intr_enable_in;
      nonsecure_sgi_level_out <= level_d;
    end
  end

endmodule : rpp_regs

//--- logic/rpp_params.svh
/*
  Offsets, field positions and reset values for the redistributor
  partition / pending-base / software-interrupt permission register slice.
  Assumes a 32-bit word-wide register port with a frame select.
*/
// Behaviour
// - security_disable set: permission register reads zero, ignores writes
// - Otherwise Secure-only; Non-secure reads zero, writes dropped
// - Permission used only under affinity routing
// - Permissions cover software interrupts, never private peripherals
// - Two-bit level per software interrupt; 11 acts as 10
// - Partition register absent without revision: reads zero
// - mem_partition_support zero: partition register reserved
// - perf_monitor_group from bits 23:16
// - partition_id from bits 15:0
// - pending_table_zero bit 62 write-only, reads zero
// - Written 1 means table may be assumed zero
// - outer_cacheability bits 58:56 drive outer attributes
// - inner_cacheability bits 9:7 drive inner attributes
// - Shareability bits 11:10; code 11 acts as 00
// - Attribute fields programmable by software
// - Address bits 51:16, 64 KiB aligned, unimplemented read zero
// - Address and attribute fields have unknown reset; here storage resets them to zero
// - Per-redistributor copy, accessible from both states
`ifndef RPP_PARAMS_SVH
`define RPP_PARAMS_SVH

`define RPP_OFS_PARTITION    12'h01c
`define RPP_OFS_PEND_LO      12'h078
`define RPP_OFS_PEND_HI      12'h07c
`define RPP_OFS_SWI_PERM     12'he00

`define RPP_PERF_GRP_LSB     16
`define RPP_PERF_GRP_MSB     23
`define RPP_PART_ID_MSB      15
`define RPP_PART_MASK        32'h00ff_ffff

`define RPP_ZERO_HINT_BIT    62
`define RPP_OUTER_LSB        56
`define RPP_OUTER_MSB        58
`define RPP_ADDR_LSB         16
`define RPP_ADDR_MSB         51
`define RPP_SHARE_LSB        10
`define RPP_SHARE_MSB        11
`define RPP_INNER_LSB        7
`define RPP_INNER_MSB        9
`define RPP_PEND_MASK        64'h070f_ffff_ffff_0f80

`define RPP_SWI_COUNT        16
`define RPP_LEVEL_RSVD       2'h3
`define RPP_LEVEL_MAX        2'h2
`define RPP_SHARE_RSVD       2'h3
`define RPP_SHARE_NONE       2'h0

`define RPP_RESET_WORD       32'h0000_0000
`define RPP_RESET_DWORD      64'h0000_0000_0000_0000

`endif

//--- logic/rpp_pkg.sv
/*
  Types for the redistributor register slice.
  Assumes rpp_params.svh carries all numeric constants.
*/
package rpp_pkg;
  typedef enum logic [0:0] {
    RPP_FRAME_CTRL = 1'b0,
    RPP_FRAME_SWI  = 1'b1
  } rpp_frame_t;
endpackage : rpp_pkg

//--- tb/rpp_checker.sv
/* Port assertions for the rpp_regs register slice.
   Assumes one clock domain; bound to rpp_regs below. */
`timescale 1ns/1ps
module rpp_checker (
  // Watched ports
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        req_in,
  input wire logic        write_in,
  input wire logic        frame_in,
  input wire logic [11:0] offset_in,
  input wire logic [31:0] wdata_in,
  input wire logic        secure_in,
  input wire logic        security_disable_in,
  input wire logic        rev_supported_in,
  input wire logic        mem_partition_support_in,
  input wire logic        affinity_routing_in,
  input wire logic        msg_intr_enable_in,
  input wire logic [31:0] rdata_out,
  input wire logic [2:0]  inner_cacheability_out,
  input wire logic        pending_table_zero_out,
  input wire logic [31:0] nonsecure_sgi_level_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire logic rd = req_in && !write_in;
  wire logic part_on = rev_supported_in && mem_partition_support_in;
  wire logic [31:0] lv = nonsecure_sgi_level_out;
  wire logic lvl_bad = |(lv & (lv >> 1) & 32'h5555_5555);
  sequence s_rd_perm;
    rd && frame_in && offset_in == 12'he00;
  endsequence
  // Two-step path: storage flop, then output flop
  sequence s_wr_low;
    req_in && write_in && !frame_in && offset_in == 12'h078 && !msg_intr_enable_in;
  endsequence
  a_perm_disabled:
    assert property (s_rd_perm ##0 security_disable_in |=> rdata_out == 32'h0)
    else $error("permission read not zero while disabled");
  a_perm_nonsecure:
    assert property (s_rd_perm ##0 !secure_in |=> rdata_out == 32'h0)
    else $error("permission read leaked to nonsecure");
  a_level_gate:
    assert property (!affinity_routing_in || security_disable_in |=> lv == 32'h0)
    else $error("levels active without affinity routing");
  a_level_rsvd:
    assert property (!lvl_bad) else $error("reserved level code on output");
  a_part_absent:
    assert property (rd && !frame_in && offset_in == 12'h01c && !part_on |=> rdata_out == 0)
    else $error("absent partition register read not zero");
  a_pend_hi_rsvd:
    assert property (rd && !frame_in && offset_in == 12'h07c
      |=> (rdata_out & ~32'h070f_ffff) == 32'h0) else $error("pending high word bits leak");
  a_attr_follow:
    assert property (s_wr_low |-> ##2 inner_cacheability_out == $past(wdata_in[9:7], 2))
    else $error("inner attribute not following write");
  a_ptz_masked:
    assert property (msg_intr_enable_in && $past(msg_intr_enable_in) |-> !pending_table_zero_out)
    else $error("zero hint shown while enabled");
endmodule : rpp_checker

bind rpp_regs rpp_checker rpp_checker_i (.*);

//--- tb/testbench.sv
/* Self-checking bench for rpp_regs.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module testbench;
  logic        ref_clk_in, rst_in, req_in, write_in, frame_in, secure_in, rvalid_out;
  logic        sdis, rev, mps, aff, en, zhint;
  logic [11:0] offset_in;
  logic [31:0] wdata_in, rdata_out, lvl, rd, w, perm;
  logic [63:0] pb;
  logic [35:0] addr;
  logic [23:0] ids;
  logic [2:0]  oc, ic;
  logic [1:0]  sh;
  integer      seed = 32569, errors = 0, cmp_count = 0;
  rpp_regs rpp_regs_i (.ref_clk_in, .rst_in, .req_in, .write_in, .frame_in, .offset_in,
    .wdata_in, .secure_in, .rvalid_out, .rdata_out, .security_disable_in(sdis),
    .rev_supported_in(rev), .mem_partition_support_in(mps), .affinity_routing_in(aff),
    .msg_intr_enable_in(en), .partition_id_out(ids[15:0]), .perf_monitor_group_out(ids[23:16]),
    .pend_addr_out(addr), .outer_cacheability_out(oc), .inner_cacheability_out(ic),
    .shareability_out(sh), .pending_table_zero_out(zhint), .nonsecure_sgi_level_out(lvl));
  initial begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task finish_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One access; read data captured the cycle after the request
  task acc(input logic wr, input logic fr, input logic [11:0] of, input logic [31:0] d,
           input logic s);
    @(posedge ref_clk_in) #1;
    {req_in, write_in, frame_in, offset_in, wdata_in, secure_in} = {1'b1, wr, fr, of, d, s};
    @(posedge ref_clk_in) #1;
    req_in = 0;
    rd = rdata_out;
    if (!wr) chk(rvalid_out, 1);
  endtask : acc
  function automatic logic [31:0] lv(input logic [31:0] p);
    for (int i = 0; i < 32; i += 2) lv[i+:2] = (p[i+:2] == 2'h3) ? 2'h2 : p[i+:2];
  endfunction : lv
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  initial begin
    {rst_in, req_in, write_in, frame_in, offset_in, wdata_in, secure_in} = '1;
    {req_in, sdis, rev, mps, aff, en} = 6'h0e;
    repeat (4) @(posedge ref_clk_in);
    #1 rst_in = 0;
    for (int i = 0; i < 8; i++) begin
      {rev, mps} = i[1:0];
      w = (i == 3) ? 32'hffff_ffff : $random(seed);
      acc(1, 0, 12'h01c, w, i[2]);
      acc(0, 0, 12'h01c, 0, ~i[2]);
      chk(rd, (rev && mps) ? w & 32'h00ff_ffff : 0);
      chk(ids, (rev && mps) ? w[23:0] : 24'h0);
    end
    $display("partition test done");
    for (int i = 0; i < 8; i++) begin
      pb = (i == 0) ? '1 : {$random(seed), $random(seed)};
      en = 0;
      acc(1, 0, 12'h078, pb[31:0], i[0]);
      acc(1, 0, 12'h07c, pb[63:32], i[1]);
      acc(0, 0, 12'h078, 0, 1);
      chk(rd, pb[31:0] & 32'hffff_0f80);
      acc(0, 0, 12'h07c, 0, 0);
      chk(rd, pb[63:32] & 32'h070f_ffff);
      chk({addr, oc, ic}, {pb[51:16], pb[58:56], pb[9:7]});
      chk(sh, (pb[11:10] == 2'h3) ? 2'h0 : pb[11:10]);
      chk(zhint, pb[62]);
      en = 1;
      repeat (2) @(posedge ref_clk_in) #1;
      chk(zhint, 0);
    end
    $display("pending base test done");
    perm = 32'hffff_ffff;
    acc(1, 1, 12'he00, perm, 1);
    for (int i = 0; i < 8; i++) begin
      {aff, sdis} = {i[2], i[0]};
      w = $random(seed);
      acc(1, 1, 12'he00, w, i[1]);
      if (!sdis && i[1]) perm = w;
      acc(0, 1, 12'he00, 0, 1);
      chk(rd, sdis ? 32'h0 : perm);
      acc(0, 1, 12'he00, 0, 0);
      chk(rd, 0);
      chk(lvl, (aff && !sdis) ? lv(perm) : 32'h0);
    end
    acc(0, 0, 12'he00, 0, 1);
    chk(rd, 0);
    acc(0, 1, 12'h078, 0, 1);
    chk(rd, 0);
    $display("permission test done");
    finish_test;
  end
endmodule : testbench
